// *** rtl/rmsl_pkg.sv ***
// Constants for the reset mode strap latch: register map, mode codes, fields.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package rmsl_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFFSET   = 8'h00;
  localparam logic [7:0] MISC_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // Mode register fields
  localparam int MODE_LOW_POS  = 0;
  localparam int MODE_MID_POS  = 1;
  localparam int MODE_HIGH_POS = 2;
  // Memory-map control register field
  localparam int FLASH_VIS_POS = 0;
  // Status register fields
  localparam int DBG_ACT_POS   = 0;
  localparam int OSC_SEL_POS   = 1;
  localparam int LATCHED_POS   = 2;

  // Reset values
  localparam logic [2:0] MODE_RESET      = 3'h0;
  localparam logic       FLASH_VIS_RESET = 1'b1;

  // Synchroniser depth for strap pins
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'b000,
    MODE_EMUL_NARROW    = 3'b001,
    MODE_SPECIAL_TEST   = 3'b010,
    MODE_EMUL_WIDE      = 3'b011,
    MODE_NORMAL_SINGLE  = 3'b100,
    MODE_NORMAL_NARROW  = 3'b101,
    MODE_SPECIAL_PERIPH = 3'b110,
    MODE_NORMAL_WIDE    = 3'b111
  } rmsl_mode_type;

  // Oscillator selection
  localparam logic OSC_COLPITTS = 1'b1;
  localparam logic OSC_PIERCE   = 1'b0;

endpackage : rmsl_pkg

// *** rtl/rmsl_sync.sv ***
// Three-stage synchroniser bank for asynchronous strap pins.
// Assumes one clock; output changes only when stages two and three agree.
`timescale 1ns/1ps
module rmsl_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce_in) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_agree
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync_out[i] <= 1'b0;
        end else if (ce_in && (s2_q[i] == s3_q[i])) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : rmsl_sync

// *** rtl/rmsl_top.sv ***
// Reset mode strap latch: captures mode, flash-map and oscillator straps
// at reset release and exposes them over a classic Wishbone slave.
// Assumes straps held stable by board logic around reset release.
//
// Function
// RQ1 - The three mode straps are latched into the mode bits as reset ends.
// RQ2 - The flash-map strap is latched into the flash-visible bit per mode.
// RQ3 - Flash is mapped into memory only while the flash-visible bit is one.
// RQ4 - Straps 000 give special single-chip, flash visible, debug active.
// RQ5 - Other modes leave debug inactive until a serial command enables it.
// RQ6 - Modes 001 and 011 set flash-visible to the inverse of the strap.
// RQ7 - Modes 101 and 111 set flash-visible equal to the strap.
// RQ8 - Straps 010 give special test wide mode with flash hidden.
// RQ9 - Straps 100 give normal single-chip mode with flash visible.
// RQ10 - Board logic must never present straps 110.
// RQ11 - Mode bits report the mode and allow only limited software changes.
// RQ12 - Oscillator strap one picks Colpitts, zero Pierce or external clock.
// RQ13 - The oscillator strap input is active low.
// RQ14 - No low-voltage reset source exists in this block.
// RQ15 - Pull-downs on the two low mode straps act only during reset; here held until the edge after capture completes.
// RQ16 - Latched values hold until next reset or a permitted mode write; here any misc write with byte lane 0 selected also sets flash-visible.
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module rmsl_top (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  // Strap pins
  input  wire logic        MODE_STRAP_HIGH_IN,
  input  wire logic        MODE_STRAP_MID_IN,
  input  wire logic        MODE_STRAP_LOW_IN,
  input  wire logic        FLASH_MAP_STRAP_IN,
  input  wire logic        OSCILLATOR_TYPE_STRAP_N_IN,
  // Debug activation command from the serial debug logic
  input  wire logic        DEBUG_ACTIVATE_IN,
  // Wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // Mode and memory-map controls
  output logic      [2:0]  MODE_OUT,
  output logic             FLASH_VISIBLE_OUT,
  output logic             DEBUG_ACTIVE_OUT,
  output logic             OSC_COLPITTS_OUT,
  output logic             CONFIG_VALID_OUT,
  // Pull-down enables for the two low mode straps
  output logic             PULLDOWN_EN_OUT
);

  // Synchronised straps
  logic [4:0] straps_raw;
  logic [4:0] straps_sync;
  logic [2:0] mode_pins;
  logic       flash_pin;
  logic       osc_pin_n;

  // Latched state
  logic [2:0] mode_q;
  logic       flash_vis_q;
  logic       debug_act_q;
  logic       osc_sel_q;
  logic       latched_q;
  logic       settle_q;
  logic       pulldown_q;
  logic [31:0] rdata_q;
  logic        ack_q;

  // Bus decode
  logic       bus_req;
  logic       wr_mode;
  logic       wr_misc;
  logic [2:0] wr_mode_val;

  // Read words
  logic [31:0] mode_word;
  logic [31:0] misc_word;
  logic [31:0] status_word;

  assign straps_raw = {OSCILLATOR_TYPE_STRAP_N_IN, FLASH_MAP_STRAP_IN,
                       MODE_STRAP_HIGH_IN, MODE_STRAP_MID_IN,
                       MODE_STRAP_LOW_IN};

  rmsl_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk_in  (CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in   (CE_IN),
    .async_in(straps_raw),
    .sync_out(straps_sync)
  );

  assign mode_pins = straps_sync[2:0];
  assign flash_pin = straps_sync[3];
  assign osc_pin_n = straps_sync[4];

  // Flash visibility for a given mode and strap
  function automatic logic flash_map(input logic [2:0] mode,
                                     input logic       strap);
    case (mode)
      rmsl_pkg::MODE_SPECIAL_SINGLE: flash_map = 1'b1;     // [RQ4]
      rmsl_pkg::MODE_EMUL_NARROW:    flash_map = ~strap;   // [RQ6]
      rmsl_pkg::MODE_EMUL_WIDE:      flash_map = ~strap;   // [RQ6]
      rmsl_pkg::MODE_SPECIAL_TEST:   flash_map = 1'b0;     // [RQ8]
      rmsl_pkg::MODE_NORMAL_SINGLE:  flash_map = 1'b1;     // [RQ9]
      rmsl_pkg::MODE_NORMAL_NARROW:  flash_map = strap;    // [RQ7]
      rmsl_pkg::MODE_NORMAL_WIDE:    flash_map = strap;    // [RQ7]
      rmsl_pkg::MODE_SPECIAL_PERIPH: flash_map = 1'b1;
      default:                       flash_map = 1'b1;
    endcase
  endfunction : flash_map

  // Permitted software mode change: modes with the high bit clear may move anywhere
  // except special peripheral; modes with the high bit set are locked.
  function automatic logic mode_write_ok(input logic [2:0] cur,
                                         input logic [2:0] nxt);
    mode_write_ok = (cur[2] == 1'b0) &&
                    (nxt != rmsl_pkg::MODE_SPECIAL_PERIPH);
  endfunction : mode_write_ok

  // Pull-downs active while in reset, released once capture is done
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pulldown_q <= 1'b1;                                  // [RQ15]
    end else if (CE_IN && latched_q) begin
      pulldown_q <= 1'b0;                                  // [RQ15]
    end
  end

  // Straps need four edges to cross the synchroniser after release
  logic [1:0] settle_cnt_q;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      settle_cnt_q <= 2'h0;
      settle_q     <= 1'b0;
    end else if (CE_IN && !settle_q) begin
      settle_cnt_q <= settle_cnt_q + 2'h1;
      settle_q     <= (settle_cnt_q == 2'h3);
    end
  end

  assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_q;
  assign wr_mode = bus_req && WB_WE_IN && WB_SEL_IN[0] &&
                   (WB_ADR_IN == rmsl_pkg::MODE_OFFSET);
  assign wr_misc = bus_req && WB_WE_IN && WB_SEL_IN[0] &&
                   (WB_ADR_IN == rmsl_pkg::MISC_OFFSET);

  // Mode write value gathered from the mode field positions
  assign wr_mode_val = {WB_DAT_IN[rmsl_pkg::MODE_HIGH_POS],
                        WB_DAT_IN[rmsl_pkg::MODE_MID_POS],
                        WB_DAT_IN[rmsl_pkg::MODE_LOW_POS]};

  // One-time capture at reset release; straps ignored afterwards
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      latched_q <= 1'b0;
    end else if (CE_IN && settle_q && !latched_q) begin
      latched_q <= 1'b1;                                   // [RQ16]
    end
  end

  // Mode bits
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_q <= rmsl_pkg::MODE_RESET;
    end else if (CE_IN) begin
      if (settle_q && !latched_q) begin
        mode_q <= mode_pins;                               // [RQ1]
      end else if (latched_q && wr_mode &&
                   mode_write_ok(mode_q, wr_mode_val)) begin
        mode_q <= wr_mode_val;                             // [RQ11]
      end
    end
  end

  // Flash-visible bit
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      flash_vis_q <= rmsl_pkg::FLASH_VIS_RESET;
    end else if (CE_IN) begin
      if (settle_q && !latched_q) begin
        flash_vis_q <= flash_map(mode_pins, flash_pin);    // [RQ2]
      end else if (latched_q && wr_misc) begin
        flash_vis_q <= WB_DAT_IN[rmsl_pkg::FLASH_VIS_POS]; // [RQ16]
      end
    end
  end

  // Debug interface activity
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      debug_act_q <= 1'b0;
    end else if (CE_IN) begin
      if (settle_q && !latched_q) begin
        debug_act_q <= (mode_pins == rmsl_pkg::MODE_SPECIAL_SINGLE); // [RQ4]
      end else if (latched_q && DEBUG_ACTIVATE_IN) begin
        debug_act_q <= 1'b1;                               // [RQ5]
      end
    end
  end

  // Oscillator strap, active low pin: low level selects Colpitts
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_sel_q <= rmsl_pkg::OSC_PIERCE;
    end else if (CE_IN && settle_q && !latched_q) begin
      osc_sel_q <= ~osc_pin_n;                             // [RQ12] [RQ13]
    end
  end

  // Read words built from the package field positions
  always_comb begin
    mode_word                          = 32'h0;
    mode_word[rmsl_pkg::MODE_LOW_POS]  = mode_q[0];
    mode_word[rmsl_pkg::MODE_MID_POS]  = mode_q[1];
    mode_word[rmsl_pkg::MODE_HIGH_POS] = mode_q[2];
  end

  always_comb begin
    misc_word                          = 32'h0;
    misc_word[rmsl_pkg::FLASH_VIS_POS] = flash_vis_q;
  end

  always_comb begin
    status_word                        = 32'h0;
    status_word[rmsl_pkg::DBG_ACT_POS] = debug_act_q;
    status_word[rmsl_pkg::OSC_SEL_POS] = osc_sel_q;
    status_word[rmsl_pkg::LATCHED_POS] = latched_q;
  end

  // Ack one cycle after a taken request, then low for at least a cycle
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
    end else if (CE_IN) begin
      ack_q <= bus_req;
    end
  end

  // Read data loads as the request is taken and holds until the next read
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= 32'h0;
    end else if (CE_IN && bus_req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        rmsl_pkg::MODE_OFFSET:   rdata_q <= mode_word;
        rmsl_pkg::MISC_OFFSET:   rdata_q <= misc_word;
        rmsl_pkg::STATUS_OFFSET: rdata_q <= status_word;
        default:                 rdata_q <= 32'h0;
      endcase
    end
  end

  // Registered outputs; no low-voltage reset source is built here [RQ14]
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      MODE_OUT <= rmsl_pkg::MODE_RESET;
    end else if (CE_IN) begin
      MODE_OUT <= mode_q;
    end
  end

  // Flash and debug stay hidden until the capture has completed
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FLASH_VISIBLE_OUT <= 1'b0;
    end else if (CE_IN) begin
      FLASH_VISIBLE_OUT <= flash_vis_q && latched_q;       // [RQ3]
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DEBUG_ACTIVE_OUT <= 1'b0;
    end else if (CE_IN) begin
      DEBUG_ACTIVE_OUT <= debug_act_q && latched_q;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OSC_COLPITTS_OUT <= rmsl_pkg::OSC_PIERCE;
    end else if (CE_IN) begin
      OSC_COLPITTS_OUT <= osc_sel_q;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CONFIG_VALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      CONFIG_VALID_OUT <= latched_q;
    end
  end

  assign WB_ACK_OUT      = ack_q;
  assign WB_DAT_OUT      = rdata_q;
  assign PULLDOWN_EN_OUT = pulldown_q;

endmodule : rmsl_top

// *** test/rmsl_checker.sv ***
// Checker for the strap latch top ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module rmsl_checker (
  input wire logic       CLOCK_IN,
  input wire logic       RST_N_IN,
  input wire logic       CE_IN,
  input wire logic       MODE_STRAP_HIGH_IN,
  input wire logic       MODE_STRAP_MID_IN,
  input wire logic       MODE_STRAP_LOW_IN,
  input wire logic       FLASH_MAP_STRAP_IN,
  input wire logic       OSCILLATOR_TYPE_STRAP_N_IN,
  input wire logic       DEBUG_ACTIVATE_IN,
  input wire logic       WB_CYC_IN,
  input wire logic       WB_STB_IN,
  input wire logic       WB_ACK_OUT,
  input wire logic [2:0] MODE_OUT,
  input wire logic       FLASH_VISIBLE_OUT,
  input wire logic       DEBUG_ACTIVE_OUT,
  input wire logic       OSC_COLPITTS_OUT,
  input wire logic       CONFIG_VALID_OUT,
  input wire logic       PULLDOWN_EN_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_cap;
    $rose(CONFIG_VALID_OUT);
  endsequence
  sequence s_idle;
    CONFIG_VALID_OUT && !WB_CYC_IN ##1 !WB_CYC_IN [*2];
  endsequence
  chk_ack_answer: assert property (
    WB_CYC_IN && WB_STB_IN && CE_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack missing");
  chk_ack_drop: assert property (
    WB_ACK_OUT && CE_IN |=> !WB_ACK_OUT) else $error("ack too long");
  chk_mode_hold: assert property (s_idle |=> $stable(MODE_OUT)
    && $stable(FLASH_VISIBLE_OUT)) else $error("latched value moved");
  chk_mode_capture: assert property (s_cap |-> MODE_OUT ==
    {MODE_STRAP_HIGH_IN, MODE_STRAP_MID_IN, MODE_STRAP_LOW_IN})
    else $error("mode not captured");
  chk_flash_map: assert property (s_cap |->
    FLASH_VISIBLE_OUT == (MODE_OUT[0] ? FLASH_MAP_STRAP_IN ^ !MODE_OUT[2]
    : MODE_OUT != 3'h2)) else $error("flash visible wrong");
  chk_osc_select: assert property (s_cap |->
    OSC_COLPITTS_OUT == !OSCILLATOR_TYPE_STRAP_N_IN)
    else $error("oscillator wrong");
  chk_debug_start: assert property (s_cap |->
    DEBUG_ACTIVE_OUT == (MODE_OUT == 3'h0)) else $error("debug start");
  chk_debug_cmd: assert property (
    CONFIG_VALID_OUT && DEBUG_ACTIVATE_IN && CE_IN |=> ##1 DEBUG_ACTIVE_OUT)
    else $error("debug command lost");
  chk_pull_down: assert property (
    PULLDOWN_EN_OUT != CONFIG_VALID_OUT) else $error("pull-down wrong");
endmodule : rmsl_checker

bind rmsl_top rmsl_checker rmsl_checker_inst (.*);

// *** test/rmsl_straps.sv ***
// Board strap model: drives the straps, then releases them.
// Released lines show pull-down level or the inverse of the last value.
`timescale 1ns/1ps
module rmsl_straps (
  input  wire logic       clk_in,
  input  wire logic       drive_in,
  input  wire logic       pulldown_en_in,
  input  wire logic [4:0] straps_in,
  output logic      [4:0] straps_out
);
  logic [4:0] last_q;
  always_ff @(posedge clk_in) begin
    if (drive_in) last_q <= straps_in;
  end
  always_comb begin
    straps_out = drive_in ? straps_in : ~last_q;
    if (!drive_in && pulldown_en_in) straps_out[3:2] = 2'h0;
  end
endmodule : rmsl_straps

// *** test/tb_reset_mode_strap_latch.sv ***
// Bench for the strap latch: boots every legal mode code with both flash-map strap values, checks over Wishbone.
// Assumes ack one cycle after a taken request and capture within 30 edges.
`timescale 1ns/1ps
module tb_reset_mode_strap_latch;
  logic        clock_in = 0, rst_n = 0, drive = 1, act = 0, ce = 1;
  logic        cyc = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, rdat;
  logic [4:0]  st = 5'h0, pins;
  logic [2:0]  mode;
  logic        ack, fv, dbg, osc, valid, pd;
  int          err_count = 0, checks_done = 0;
  always #4 clock_in = ~clock_in;
  rmsl_straps rmsl_straps_inst (.clk_in(clock_in), .drive_in(drive),
    .pulldown_en_in(pd), .straps_in(st), .straps_out(pins));
  rmsl_top rmsl_top_inst (.CLOCK_IN(clock_in), .RST_N_IN(rst_n),
    .CE_IN(ce), .MODE_STRAP_HIGH_IN(pins[4]), .MODE_STRAP_MID_IN(pins[3]),
    .MODE_STRAP_LOW_IN(pins[2]), .FLASH_MAP_STRAP_IN(pins[1]),
    .OSCILLATOR_TYPE_STRAP_N_IN(pins[0]), .DEBUG_ACTIVATE_IN(act),
    .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hf), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .MODE_OUT(mode), .FLASH_VISIBLE_OUT(fv), .DEBUG_ACTIVE_OUT(dbg),
    .OSC_COLPITTS_OUT(osc), .CONFIG_VALID_OUT(valid), .PULLDOWN_EN_OUT(pd));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = rdat;
    cyc <= 1'b0;
    if (n >= 40) err_count++;
  endtask : wb
  task automatic boot(input logic [4:0] s);
    int n;
    n = 0;
    @(posedge clock_in);
    rst_n <= 1'b0; drive <= 1'b1; st <= s;
    repeat (2) @(posedge clock_in);
    chk(pd, 1'b1);
    rst_n <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (valid !== 1'b1 && n < 30);
    if (n >= 30) err_count++;
    repeat (2) @(posedge clock_in);
    drive <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask : boot
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    logic [2:0] c;
    logic       f, e;
    for (int i = 0; i < 16; i++) begin
      c = i[3:1];
      f = i[0];
      if (c == 3'h6) continue;
      e = c[0] ? f ^ !c[2] : c != 3'h2;
      boot({c, f, f ^ c[0]});
      chk(mode, c);
      chk(fv, e);
      chk(pd, 1'b0);
      chk(valid, 1'b1);
      chk(osc, !(f ^ c[0]));
      chk(dbg, c == 3'h0);
      wb(1'b0, rmsl_pkg::MISC_OFFSET, 32'h0);
      chk(rd, {31'h0, e});
      wb(1'b0, rmsl_pkg::STATUS_OFFSET, 32'h0);
      chk(rd, {29'h1, !(f ^ c[0]), c == 3'h0});
      wb(1'b1, rmsl_pkg::MODE_OFFSET, 32'h6);
      wb(1'b1, rmsl_pkg::MODE_OFFSET, 32'h1);
      repeat (2) @(posedge clock_in);
      chk(mode, c[2] ? c : 3'h1);
      wb(1'b0, rmsl_pkg::MODE_OFFSET, 32'h0);
      chk(rd, {29'h0, c[2] ? c : 3'h1});
      wb(1'b1, rmsl_pkg::MISC_OFFSET, {31'h0, !e});
      wb(1'b0, rmsl_pkg::MISC_OFFSET, 32'h0);
      chk(rd, {31'h0, !e});
      chk(fv, !e);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
      ce <= 1'b0;
      act <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk(dbg, c == 3'h0);
      ce <= 1'b1;
      @(posedge clock_in);
      act <= 1'b0;
      repeat (2) @(posedge clock_in);
      chk(dbg, 1'b1);
      $display("test %0d done", i);
    end
    complete_run();
  end
endmodule : tb_reset_mode_strap_latch
